// File: rtl/adc_seq_defines.vh
// Timing and layout constants for the converter sequencer.
// Assumes a 25 MHz sequencer clock; counts derive from the period.
`ifndef ADC_SEQ_DEFINES_VH
`define ADC_SEQ_DEFINES_VH
`define CLK_PERIOD_NS    40
`define RESULT_WIDTH     16
// Longest conversion, rounded down to whole cycles
`define CONV_TIME_NS     2500
`define CONV_CYCLES      (`CONV_TIME_NS / `CLK_PERIOD_NS)
// Acquisition start after conversion start, rounded up
`define ACQ_DELAY_NS     750
`define ACQ_CYCLES       ((`ACQ_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Reinitialisation window after supply returns, rounded up
`define POR_WAIT_NS      20000
`define POR_CYCLES       ((`POR_WAIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Least trigger low time before a wake-up start, rounded up
`define WAKE_LOW_NS      200
`define WAKE_CYCLES      ((`WAKE_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Reset values
`define RESULT_RESET     16'h0000
`endif

// File: rtl/sar_adc_conversion_serial_readout.v
// Conversion sequencer and serial readout of a 16-bit SAR converter.
// Assumes all host pins and the supply monitor are asynchronous to
// ref_clk_in; the serial clock is sampled and its edges detected here.
// Limitation: each serial clock phase must span two or more
// ref_clk_in cycles, or the sampler misses an edge.
// sample_data_in is same-domain and taken as it stands at start.
// Conversion time is a counter; the result is a captured word.
// Supply loss acts as a reset at any time, even mid-conversion.
// Mode pin may change only between frames.
// Every output is registered; none comes from logic.
`timescale 1ns/1ps
`include "adc_seq_defines.vh"

module sar_adc_conversion_serial_readout #(
   parameter WIDTH = `RESULT_WIDTH
) (
   input  wire             ref_clk_in,
   input  wire             reset_in,
   input  wire             supply_good_in,
   input  wire             conversion_trigger_in,
   input  wire             sck_in,
   input  wire             read_select_serial_in_in,
   input  wire             chain_mode_in,
   input  wire [WIDTH-1:0] sample_data_in,
   output wire             busy_out,
   output wire             acquiring_out,
   output wire             powered_down_out,
   output wire             ready_out,
   output wire             wake_ok_out,
   output wire             sdo_out,
   output wire             sdo_oe_out
);

   // Sequencer states
   localparam [1:0] ST_POR   = 2'h0;
   localparam [1:0] ST_IDLE  = 2'h1;
   localparam [1:0] ST_CONV  = 2'h2;
   localparam [1:0] ST_PDOWN = 2'h3;

   // Counts worked out at full width, then cut to counter width
   localparam integer CONV_LAST_I = `CONV_CYCLES - 1;
   localparam integer ACQ_AT_I    = `ACQ_CYCLES;
   localparam integer POR_LAST_I  = `POR_CYCLES - 1;
   localparam integer WAKE_MIN_I  = `WAKE_CYCLES;

   // Counter widths fit the documented counts with no headroom
   localparam [5:0] CONV_LAST = CONV_LAST_I[5:0];
   localparam [5:0] ACQ_AT    = ACQ_AT_I[5:0];
   localparam [8:0] POR_LAST  = POR_LAST_I[8:0];
   localparam [2:0] WAKE_MIN  = WAKE_MIN_I[2:0];

   // Two-stage synchronisers, first stage read only by second
   reg [4:0] sync1_reg;
   reg [4:0] sync2_reg;
   reg       sck_prev_reg;
   reg       trig_prev_reg;

   // Synchronised pin levels, one bit each
   wire supply_ok = sync2_reg[0];
   wire trig      = sync2_reg[1];
   wire sck       = sync2_reg[2];
   wire read_select_serial_in   = sync2_reg[3];
   wire chain     = sync2_reg[4];

   // Pin sampling into the sequencer clock domain
   always @(posedge ref_clk_in) begin
      if (reset_in) begin
         // Select resets high so SDO stays off until the pin is seen
         sync1_reg     <= 5'h08;
         sync2_reg     <= 5'h08;
         sck_prev_reg  <= 1'b0;
         trig_prev_reg <= 1'b0;
      end else begin
         // Levels first; edge history trails one cycle
         sync1_reg     <= {chain_mode_in, read_select_serial_in_in, sck_in,
                           conversion_trigger_in, supply_good_in};
         sync2_reg     <= sync1_reg;
         sck_prev_reg  <= sck;
         trig_prev_reg <= trig;
      end
   end

   // Edge detects; reset values match the idle pin levels
   wire sck_rise  = sck & ~sck_prev_reg;
   wire trig_rise = trig & ~trig_prev_reg;

   // Sequencer registers
   reg [1:0]       state_reg;
   reg [1:0]       state_next;
   // Conversion, reinit and wake counters
   reg [5:0]       conv_cnt_reg;
   reg [5:0]       conv_cnt_next;
   reg [8:0]       por_cnt_reg;
   reg [8:0]       por_cnt_next;
   reg [2:0]       low_cnt_reg;
   reg [2:0]       low_cnt_next;

   // Captured sample and status flags
   reg [WIDTH-1:0] held_reg;
   reg [WIDTH-1:0] held_next;
   reg             busy_reg;
   reg             busy_next;
   reg             acq_reg;
   reg             acq_next;
   reg             pdown_reg;
   reg             pdown_next;
   reg             ready_reg;
   reg             ready_next;
   reg             wake_reg;
   reg             wake_next;

   // Load strobe towards the shift register
   reg             load;

   // Next-state logic for conversion, acquisition and power-down
   always @* begin
      state_next    = state_reg;
      conv_cnt_next = conv_cnt_reg;
      por_cnt_next  = por_cnt_reg;
      low_cnt_next  = low_cnt_reg;
      held_next     = held_reg;
      busy_next     = busy_reg;
      acq_next      = acq_reg;
      pdown_next    = pdown_reg;
      ready_next    = ready_reg;
      wake_next     = wake_reg;
      load          = 1'b0;
      // Low time seen on the trigger, saturating
      if (trig) begin
         low_cnt_next = 3'h0;
      end else if (low_cnt_reg != WAKE_MIN) begin
         low_cnt_next = low_cnt_reg + 3'h1;
      end
      wake_next = (low_cnt_next == WAKE_MIN);
      // Supply monitor first; it overrides every state
      if (!supply_ok) begin
         // Supply lost: hold state, counters, result and flags in reset; wake counter and wake flag run on
         state_next    = ST_POR;
         por_cnt_next  = 9'h000;
         conv_cnt_next = 6'h00;
         busy_next     = 1'b0;
         acq_next      = 1'b0;
         pdown_next    = 1'b0;
         ready_next    = 1'b0;
         held_next     = `RESULT_RESET;
      end else begin
         case (state_reg)
            ST_POR: begin
               // Reinit window; starts are not taken until it ends
               if (por_cnt_reg == POR_LAST) begin
                  state_next = ST_IDLE;
                  ready_next = 1'b1;
                  acq_next   = 1'b1;
               end else begin
                  // Count on through the window
                  por_cnt_next = por_cnt_reg + 9'h001;
               end
            end
            ST_IDLE, ST_PDOWN: begin
               // Start only from idle or power-down
               if (trig_rise) begin
                  state_next    = ST_CONV;
                  conv_cnt_next = 6'h00;
                  busy_next     = 1'b1;
                  acq_next      = 1'b0;
                  pdown_next    = 1'b0;
                  held_next     = sample_data_in;
               end else if (state_reg == ST_PDOWN && !trig) begin
                  // Trigger low wakes the converter; result untouched
                  state_next = ST_IDLE;
                  pdown_next = 1'b0;
               end
            end
            ST_CONV: begin
               // Trigger edges here are not looked at
               // Last count ends the conversion and loads the result
               if (conv_cnt_reg == CONV_LAST) begin
                  busy_next  = 1'b0;
                  load       = 1'b1;
                  state_next = trig ? ST_PDOWN : ST_IDLE;
                  pdown_next = trig;
               end else begin
                  // Still counting; acquisition may open meanwhile
                  conv_cnt_next = conv_cnt_reg + 6'h01;
               end
               // Next acquisition overlaps the rest of the conversion
               if (conv_cnt_next == ACQ_AT) begin
                  acq_next = 1'b1;
               end
            end
            default: begin
               // Unused code falls back to reinit
               state_next = ST_POR;
            end
         endcase
      end
   end

   // Sequencer state update
   always @(posedge ref_clk_in) begin
      if (reset_in) begin
         // Result cleared and every flag low
         state_reg    <= ST_POR;
         conv_cnt_reg <= 6'h00;
         por_cnt_reg  <= 9'h000;
         low_cnt_reg  <= 3'h0;
         held_reg     <= `RESULT_RESET;
         busy_reg     <= 1'b0;
         acq_reg      <= 1'b0;
         pdown_reg    <= 1'b0;
         ready_reg    <= 1'b0;
         wake_reg     <= 1'b0;
      end else begin
         // All next values taken together
         state_reg    <= state_next;
         conv_cnt_reg <= conv_cnt_next;
         por_cnt_reg  <= por_cnt_next;
         low_cnt_reg  <= low_cnt_next;
         held_reg     <= held_next;
         busy_reg     <= busy_next;
         acq_reg      <= acq_next;
         pdown_reg    <= pdown_next;
         ready_reg    <= ready_next;
         wake_reg     <= wake_next;
      end
   end

   // Output shift register and drive enable
   reg [WIDTH-1:0] shift_reg;
   reg [WIDTH-1:0] shift_next;
   reg             oe_reg;
   reg             oe_next;

   // Shift only when selected, or always in chain mode
   wire shift_en = chain | ~read_select_serial_in;
   // Normal mode fills zeros in behind the result
   wire sdi_bit  = chain ? read_select_serial_in : 1'b0;

   // Load beats shift so a fresh result is never lost
   always @* begin
      shift_next = shift_reg;
      // Enable trails the pins by three cycles
      oe_next    = chain | ~read_select_serial_in;
      if (!supply_ok) begin
         // Supply loss clears the word
         shift_next = `RESULT_RESET;
      end else if (load) begin
         shift_next = held_reg;
      end else if (sck_rise && shift_en) begin
         // MSB has stood since load; moves only on a clock rise
         shift_next = {shift_reg[WIDTH-2:0], sdi_bit};
      end
   end

   // Read select falling reloads nothing; MSB already waits on top
   always @(posedge ref_clk_in) begin
      if (reset_in) begin
         shift_reg    <= `RESULT_RESET;
         oe_reg       <= 1'b0;
      end else begin
         shift_reg    <= shift_next;
         oe_reg       <= oe_next;
      end
   end

   // Status flags, all straight from flip-flops
   assign busy_out         = busy_reg;
   assign acquiring_out    = acq_reg;
   assign powered_down_out = pdown_reg;
   assign ready_out        = ready_reg;
   assign wake_ok_out      = wake_reg;

   // Serial pins from the shift register and enable flop
   assign sdo_out          = shift_reg[WIDTH-1];
   assign sdo_oe_out       = oe_reg;

endmodule

// File: testbench/adc_seq_monitor.sv
// Port checker for the converter sequencer.
// Assumes a bind onto the sequencer top.
`timescale 1ns/1ps
module adc_seq_monitor (
   input wire ref_clk_in,
   input wire reset_in,
   input wire supply_good_in,
   input wire conversion_trigger_in,
   input wire sck_in,
   input wire read_select_serial_in_in,
   input wire chain_mode_in,
   input wire busy_out,
   input wire acquiring_out,
   input wire powered_down_out,
   input wire ready_out,
   input wire sdo_out,
   input wire sdo_oe_out
);
   logic [9:0] por_cnt_reg;
   // Cycles since reset or supply loss, saturating
   always @(posedge ref_clk_in)
      if (reset_in || !supply_good_in)
         por_cnt_reg <= 10'h000;
      else if (por_cnt_reg != 10'h3FF)
         por_cnt_reg <= por_cnt_reg + 10'h001;
   default clocking @(posedge ref_clk_in); endclocking
   // Supply loss restarts everything, so checks pause
   default disable iff (reset_in || !supply_good_in);
   conv_len_a: assert property ($rose(busy_out) |->
      (busy_out throughout ##61 1'b1) ##1 !busy_out) else $error("busy length");
   logic [5:0] busy_cnt_reg;
   // Cycles busy has stood, saturating; replaces a long repetition
   always @(posedge ref_clk_in)
      if (reset_in || !busy_out)
         busy_cnt_reg <= 6'h00;
      else if (busy_cnt_reg != 6'h3F)
         busy_cnt_reg <= busy_cnt_reg + 6'h01;
   acq_delay_a: assert property (busy_out && busy_cnt_reg < 6'h13 |-> !acquiring_out)
      else $error("acquire early");
   acq_start_a: assert property (busy_out && busy_cnt_reg == 6'h13 |-> acquiring_out)
      else $error("acquire late");
   pdown_entry_a: assert property ($fell(busy_out) && conversion_trigger_in
      && $past(conversion_trigger_in, 4) |-> powered_down_out) else $error("no pdown");
   pdown_idle_a: assert property (powered_down_out |-> !busy_out)
      else $error("pdown while busy");
   oe_on_a: assert property ((chain_mode_in || !read_select_serial_in_in) [*7]
      |-> sdo_oe_out) else $error("sdo not driven");
   oe_off_a: assert property ((!chain_mode_in && read_select_serial_in_in) [*7]
      |-> !sdo_oe_out) else $error("sdo driven");
   ready_time_a: assert property ($rose(ready_out) |->
      por_cnt_reg >= 10'h1F3 && por_cnt_reg <= 10'h1FA) else $error("ready time");
   ready_gate_a: assert property (!ready_out |-> !busy_out)
      else $error("busy before ready");
   sdo_hold_a: assert property ((!sck_in && !busy_out) [*6] |-> $stable(sdo_out))
      else $error("sdo moved");
   cover property ($fell(busy_out) && powered_down_out);
   cover property (chain_mode_in && $rose(sck_in));
   cover property ($rose(ready_out));
endmodule

// File: testbench/adc_host_model.sv
// Host model: trigger, serial clock, read select.
// Assumes the bench calls its tasks; pins move 1ns after clock rise.
`timescale 1ns/1ps
module adc_host_model (
   input  wire  ref_clk_in,
   input  wire  sdo_in,
   output logic cnv_out,
   output logic sck_out,
   output logic rsel_out
);
   // Idle: serial clock still, select high
   initial begin
      cnv_out = 1'b0;
      sck_out = 1'b0;
      rsel_out = 1'b1;
   end
   task step(input int k);
      repeat (k) @(posedge ref_clk_in);
      #1;
   endtask
   // Low over the wake time, then one clean rise held high
   task start;
      cnv_out = 1'b0;
      step(6);
      cnv_out = 1'b1;
   endtask
   // One frame of n bits, sampled just before each rise
   task xfer(input int n, input logic [31:0] up, input logic chain,
             output logic [31:0] got);
      got = 32'h0000_0000;
      rsel_out = chain ? up[n-1] : 1'b0;
      for (int i = 0; i < n; i++) begin
         step(4);
         got = {got[30:0], sdo_in};
         sck_out = 1'b1;
         step(2);
         if (chain && i < n - 1)
            rsel_out = up[n-2-i];
         step(2);
         sck_out = 1'b0;
      end
      step(4);
      rsel_out = 1'b1;
   endtask
endmodule

// File: testbench/sar_adc_conversion_serial_readout_tb_top.sv
// Bench for the converter sequencer.
// Assumes adc_host_model drives the host pins.
`timescale 1ns/1ps
module sar_adc_conversion_serial_readout_tb_top;
   logic        ref_clk_in;
   logic        reset_in;
   logic        supply_good_in;
   logic        chain_mode_in;
   logic [15:0] sample_data_in;
   wire         conversion_trigger, sck, rsel, busy, acq, pdn, rdy, sdo, oe, wk;
   wire         sdo_w = oe ? sdo : 1'bz;
   int          err_count = 0;
   int          num_checks = 0;
   int          c;
   logic [31:0] got;
   always #20 ref_clk_in = ~ref_clk_in;
   sar_adc_conversion_serial_readout dut_u (.ref_clk_in(ref_clk_in), .reset_in(reset_in),
      .supply_good_in(supply_good_in), .conversion_trigger_in(conversion_trigger), .sck_in(sck),
      .read_select_serial_in_in(rsel), .chain_mode_in(chain_mode_in),
      .sample_data_in(sample_data_in), .busy_out(busy), .acquiring_out(acq),
      .powered_down_out(pdn), .ready_out(rdy), .wake_ok_out(wk), .sdo_out(sdo),
      .sdo_oe_out(oe));
   adc_host_model host_u (.ref_clk_in(ref_clk_in), .sdo_in(sdo_w), .cnv_out(conversion_trigger),
      .sck_out(sck), .rsel_out(rsel));
   task check(input string name, input logic [31:0] exp, input logic [31:0] seen);
      num_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected %s: expected %h, seen %h", name, exp, seen);
      end
   endtask
   task stop_test;
      $display("checks %0d, errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // Bounded wait for a level on busy or ready, counting cycles
   task wait_for(input logic sel, input logic lvl, input int lim);
      c = 0;
      while ((sel ? rdy : busy) !== lvl && c < lim) begin
         host_u.step(1);
         c++;
      end
      if (c >= lim) begin
         err_count++;
         $display("unexpected wait_for: expected level %0d, seen timeout", lvl);
      end
   endtask
   // Early trigger is ignored, ready after the reinit window
   task t_por;
      host_u.start();
      host_u.step(3);
      check("early_busy", 0, busy);
      wait_for(1, 1, 600);
      check("por_window", 1, c + 10 >= 495 && c + 10 <= 510);
   endtask
   // Conversion with a stray trigger pulse, then normal readout
   task t_normal;
      sample_data_in = 16'hA5C3;
      host_u.start();
      wait_for(0, 1, 10);
      host_u.cnv_out = 1'b0;
      host_u.step(2);
      host_u.cnv_out = 1'b1;
      wait_for(0, 0, 100);
      check("busy_cycles", 62, c + 2);
      check("pdown", 1, pdn);
      check("acq_on", 1, acq);
      check("wake_busy", 0, wk);
      host_u.xfer(16, 32'h0, 1'b0, got);
      check("normal_word", 16'hA5C3, got);
      check("pdown_kept", 1, pdn);
      host_u.step(8);
      check("oe_off", 0, oe);
   endtask
   // Wake, convert, then chain readout of own and upstream word
   task t_chain;
      chain_mode_in = 1'b1;
      sample_data_in = 16'h3C5A;
      host_u.cnv_out = 1'b0;
      host_u.step(8);
      check("wake", 0, pdn);
      check("wake_ok", 1, wk);
      host_u.start();
      wait_for(0, 1, 20);
      wait_for(0, 0, 100);
      check("chain_oe", 1, oe);
      host_u.xfer(32, {16'h9E17, 16'h0000}, 1'b1, got);
      check("chain_word", 32'h3C5A9E17, got);
      chain_mode_in = 1'b0;
   endtask
   // Supply loss clears state, then reinitialises
   task t_supply;
      supply_good_in = 1'b0;
      host_u.step(6);
      check("drop_ready", 0, rdy);
      check("drop_pdown", 0, pdn);
      supply_good_in = 1'b1;
      wait_for(1, 1, 600);
      check("reinit", 1, c >= 495 && c <= 510);
   endtask
   // Main sequence after a three-cycle reset
   initial begin
      ref_clk_in = 1'b0;
      reset_in = 1'b1;
      supply_good_in = 1'b1;
      chain_mode_in = 1'b0;
      sample_data_in = 16'h0000;
      host_u.step(3);
      reset_in = 1'b0;
      t_por();
      t_normal();
      t_chain();
      t_supply();
      stop_test();
   end
   // Watchdog well past the expected run
   initial begin
      #200000;
      err_count++;
      stop_test();
   end
endmodule
bind sar_adc_conversion_serial_readout adc_seq_monitor mon_u (.ref_clk_in(ref_clk_in),
   .reset_in(reset_in), .supply_good_in(supply_good_in),
   .conversion_trigger_in(conversion_trigger_in), .sck_in(sck_in),
   .read_select_serial_in_in(read_select_serial_in_in), .chain_mode_in(chain_mode_in),
   .busy_out(busy_out), .acquiring_out(acquiring_out), .powered_down_out(powered_down_out),
   .ready_out(ready_out), .sdo_out(sdo_out), .sdo_oe_out(sdo_oe_out));
